// file: common/smp_pkg.sv
// Shared constants, types and keyword tree for the program message parser
package smp_pkg;

  // ----------------------------------------------------------------
  // Character codes and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_NL    = 8'h0A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam int         KW_CHARS   = 12;
  localparam int         KW_COUNT   = 25;
  localparam int         FIFO_WIDTH = 9;
  localparam int         FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Reset values, error queue limit and status byte layout
  // ----------------------------------------------------------------
  localparam logic [4:0] ROOT_NODE     = 5'h00;
  localparam logic [2:0] ERR_QUEUE_MAX = 3'h7;
  localparam int         STB_ERR_BIT   = 3;
  localparam int         STB_MAV_BIT   = 4;

  typedef enum logic [1:0] {SMP_ERR_HEADER, SMP_ERR_SEPARATOR, SMP_ERR_PARAM} smp_err_t;

  // Long form, parent node, optional flag, long-form-only flag
  typedef struct packed {
    logic [KW_CHARS*8-1:0] name;
    logic [4:0]            parent;
    logic                  opt;
    logic                  long_only;
  } smp_kw_t;

  // ----------------------------------------------------------------
  // Command tree; entry 0 is the root and never matches
  // ----------------------------------------------------------------
  localparam smp_kw_t KW_TABLE [KW_COUNT] = '{
    '{96'h0,           5'h00, 1'b0, 1'b0},
    '{"ABORT",         5'h00, 1'b0, 1'b0},
    '{"CALIBRATE",     5'h00, 1'b0, 1'b0},
    '{"DISPLAY",       5'h00, 1'b0, 1'b0},
    '{"INITIATE",      5'h00, 1'b0, 1'b0},
    '{"LIST",          5'h00, 1'b0, 1'b0},
    '{"MEASURE",       5'h00, 1'b0, 1'b0},
    '{"OUTPUT",        5'h00, 1'b0, 1'b0},
    '{"SOURCE",        5'h00, 1'b1, 1'b0},
    '{"STATUS",        5'h00, 1'b0, 1'b0},
    '{"SYSTEM",        5'h00, 1'b0, 1'b0},
    '{"TRIGGER",       5'h00, 1'b0, 1'b0},
    '{"VOLTAGE",       5'h08, 1'b0, 1'b0},
    '{"CURRENT",       5'h08, 1'b0, 1'b0},
    '{"FUNCTION",      5'h08, 1'b0, 1'b0},
    '{"OPERATION",     5'h09, 1'b0, 1'b0},
    '{"PRESET",        5'h09, 1'b0, 1'b1},
    '{"QUESTIONABLE",  5'h09, 1'b0, 1'b0},
    '{"CONDITION",     5'h0F, 1'b0, 1'b0},
    '{"ENABLE",        5'h0F, 1'b0, 1'b0},
    '{"EVENT",         5'h0F, 1'b0, 1'b0},
    '{"VOLTAGE",       5'h06, 1'b0, 1'b0},
    '{"CURRENT",       5'h06, 1'b0, 1'b0},
    '{"LEVEL",         5'h0C, 1'b0, 1'b0},
    '{"ERROR",         5'h0A, 1'b0, 1'b0}
  };

endpackage

// file: rtl/smp_parser.sv
// Program message parser with its input character FIFO
// Contract
// - Newline 0x0A alone ends a message
// - Character with line_end_strobe ends message
// - Short form: whole, first four, or three
// - Only exact short or long forms match
// - Keyword matching ignores letter case
// - Designated keywords accept long form only
// - Colon separator moves one level deeper
// - Question mark after keyword makes query
// - Parameter follows single space after header
// - Semicolon separates message units
// - Leading colon resets path to root
// - Terminator or root specifier returns root
// - Next unit resolves at previous separator level
// - Optional keywords may be omitted
// - Root accepts only listed branch keywords
// - Status bit 3 set while errors queued
// - Status bit 4 set when response waits
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Character FIFO
// ------------------------------------------------------------------
module smp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } smp_fifo_t;

  smp_fifo_t s;
  smp_fifo_t next_s;
  logic      push;
  logic      pop;

  assign push      = in_valid && s.rdy;
  assign pop       = out_valid && out_ready;
  assign in_ready  = s.rdy;
  assign out_valid = s.cnt != '0;
  assign out_data  = s.mem[s.rd];

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop)
      next_s.rd = s.rd + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Ready is registered from the next count, so it drops only once the FIFO holds DEPTH entries
    next_s.rdy = next_s.cnt < (AW+1)'(DEPTH);
  end

  always_ff @(posedge mclk)
    if (rst)
      s <= '0;
    else
      s <= next_s;
endmodule

// ------------------------------------------------------------------
// Parser
// ------------------------------------------------------------------
module smp_parser (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       char_valid,
  input  wire logic [7:0] char_data,
  input  wire logic       line_end_strobe,
  output logic            char_ready,
  output logic            tok_valid,
  input  wire logic       tok_ready,
  output logic            tok_is_param,
  output logic      [4:0] tok_node,
  output logic            tok_query,
  output logic      [7:0] tok_data,
  output logic            err_pulse,
  output logic      [1:0] err_code,
  input  wire logic       err_ack,
  input  wire logic       resp_taken,
  output logic      [7:0] status_byte,
  output logic      [4:0] path_level
);
  typedef enum logic [2:0] {S_START, S_KWSTART, S_KW, S_AFTQ, S_PFIRST, S_PARAM,
                            S_DISCARD} smp_st_t;
  typedef struct packed {
    smp_st_t    st;
    logic [4:0] level;
    logic [95:0] kbuf;
    logic [3:0] klen;
    logic       tok_valid;
    logic       tok_is_param;
    logic [4:0] tok_node;
    logic       tok_query;
    logic [7:0] tok_data;
    logic       err_pulse;
    logic [1:0] err_code;
    logic [2:0] err_cnt;
    logic       mav;
    logic [7:0] stb;
  } smp_state_t;

  smp_state_t s;
  smp_state_t next_s;
  logic       f_valid;
  logic [8:0] f_data;
  logic       pop;
  logic [7:0] ch;
  logic       term;
  logic       letter;
  logic       hit;
  logic [4:0] hit_idx;
  logic       raise;
  logic [1:0] raise_code;

  smp_fifo #(.WIDTH(smp_pkg::FIFO_WIDTH), .DEPTH(smp_pkg::FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (char_valid),
    .in_data   ({line_end_strobe, char_data}),
    .in_ready  (char_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (pop)
  );

  function automatic logic is_vowel(logic [7:0] c);
    return c == 8'h41 || c == 8'h45 || c == 8'h49 || c == 8'h4F || c == 8'h55;
  endfunction

  function automatic logic kw_match(smp_pkg::smp_kw_t e, logic [95:0] b, logic [3:0] n);
    int   l;
    int   sl;
    int   sh;
    logic ok;
    l = 0;
    for (int j = 0; j < smp_pkg::KW_CHARS; j++)
      if (e.name[j*8 +: 8] != 8'h00)
        l = j + 1;
    if (l <= 4)
      sl = l;
    else if (is_vowel(e.name[(l-4)*8 +: 8]))
      sl = 3;
    else
      sl = 4;
    ok = (n != 4'h0) && ((int'(n) == l) || (int'(n) == sl && !e.long_only));
    sh = (int'(n) == l) ? 0 : l - sl;
    for (int j = 0; j < smp_pkg::KW_CHARS; j++)
      if (j < int'(n))
      begin
        if (b[j*8 +: 8] != e.name[(j+sh)*8 +: 8])
          ok = 1'b0;
      end
    return ok;
  endfunction

  // Drain stalls only while an undelivered token is waiting
  assign pop    = f_valid && (!s.tok_valid || tok_ready);
  assign ch     = f_data[7:0];
  assign term   = f_data[8] || ch == smp_pkg::CH_NL;
  assign letter = (ch >= 8'h41 && ch <= 8'h5A) || (ch >= 8'h61 && ch <= 8'h7A);

  // All entries but the root compared in parallel so a lookup never costs extra cycles
  always_comb
  begin
    smp_pkg::smp_kw_t e;
    smp_pkg::smp_kw_t p;
    e       = '0;
    p       = '0;
    hit     = 1'b0;
    hit_idx = smp_pkg::ROOT_NODE;
    for (int i = smp_pkg::KW_COUNT - 1; i > 0; i--)
    begin
      e = smp_pkg::KW_TABLE[i];
      p = smp_pkg::KW_TABLE[e.parent];
      if (kw_match(e, s.kbuf, s.klen) &&
          (e.parent == s.level || (p.opt && p.parent == s.level)))
      begin
        hit     = 1'b1;
        hit_idx = 5'(i);
      end
    end
  end

  always_comb
  begin
    next_s           = s;
    raise            = 1'b0;
    raise_code       = 2'(smp_pkg::SMP_ERR_HEADER);
    next_s.tok_valid = s.tok_valid && !tok_ready;
    next_s.err_pulse = 1'b0;
    if (err_ack && s.err_cnt != 3'h0)
      next_s.err_cnt = s.err_cnt - 3'h1;
    if (resp_taken)
      next_s.mav = 1'b0;
    if (s.tok_valid && tok_ready && !s.tok_is_param && s.tok_query)
      next_s.mav = 1'b1;
    if (pop)
    begin
      case (s.st)
        S_START, S_KWSTART:
          if (letter)
          begin
            next_s.kbuf = {88'h0, ch & 8'hDF};
            next_s.klen = 4'h1;
            next_s.st   = S_KW;
          end
          else if (ch == smp_pkg::CH_COLON && s.st == S_START && !term)
          begin
            next_s.level = smp_pkg::ROOT_NODE;
            next_s.st    = S_KWSTART;
          end
          else if (!(term && s.st == S_START))
          begin
            raise      = 1'b1;
            raise_code = 2'(smp_pkg::SMP_ERR_SEPARATOR);
          end
        S_KW:
          if (letter && !term)
          begin
            if (s.klen == 4'(smp_pkg::KW_CHARS))
              raise = 1'b1;
            next_s.kbuf = {s.kbuf[87:0], ch & 8'hDF};
            next_s.klen = s.klen + 4'h1;
          end
          else if (!hit || !(term || ch == smp_pkg::CH_COLON || ch == smp_pkg::CH_QUERY ||
                   ch == smp_pkg::CH_SPACE || ch == smp_pkg::CH_SEMI))
            raise = 1'b1;
          else if (ch == smp_pkg::CH_COLON && !term)
          begin
            next_s.level = hit_idx;
            next_s.st    = S_KWSTART;
          end
          else
          begin
            next_s.tok_valid    = 1'b1;
            next_s.tok_is_param = 1'b0;
            next_s.tok_node     = hit_idx;
            next_s.tok_query    = ch == smp_pkg::CH_QUERY && !term;
            next_s.tok_data     = 8'h00;
            if (ch == smp_pkg::CH_QUERY && !term)
              next_s.st = S_AFTQ;
            else if (ch == smp_pkg::CH_SPACE && !term)
              next_s.st = S_PFIRST;
            else
              next_s.st = S_START;
          end
        S_AFTQ:
          if (ch == smp_pkg::CH_SPACE && !term)
            next_s.st = S_PFIRST;
          else if (ch == smp_pkg::CH_SEMI || term)
            next_s.st = S_START;
          else
          begin
            raise      = 1'b1;
            raise_code = 2'(smp_pkg::SMP_ERR_SEPARATOR);
          end
        S_PFIRST, S_PARAM:
          if (s.st == S_PFIRST && (term || ch == smp_pkg::CH_SEMI || ch == smp_pkg::CH_SPACE))
          begin
            raise      = 1'b1;
            raise_code = 2'(smp_pkg::SMP_ERR_PARAM);
          end
          else if (ch == smp_pkg::CH_SEMI || term)
            next_s.st = S_START;
          else
          begin
            next_s.tok_valid    = 1'b1;
            next_s.tok_is_param = 1'b1;
            next_s.tok_node     = s.tok_node;
            next_s.tok_query    = 1'b0;
            next_s.tok_data     = ch;
            next_s.st           = S_PARAM;
          end
        S_DISCARD:
          next_s.st = S_DISCARD;
        default:
          next_s.st = S_START;
      endcase
      if (raise)
      begin
        next_s.st        = S_DISCARD;
        next_s.level     = smp_pkg::ROOT_NODE;
        next_s.err_pulse = 1'b1;
        next_s.err_code  = raise_code;
        if (next_s.err_cnt != smp_pkg::ERR_QUEUE_MAX)
          next_s.err_cnt = next_s.err_cnt + 3'h1;
      end
      if (term)
      begin
        next_s.st    = S_START;
        next_s.level = smp_pkg::ROOT_NODE;
      end
    end
    // Built from next values so the status byte leaves a flip-flop yet keeps its timing
    next_s.stb                       = 8'h00;
    next_s.stb[smp_pkg::STB_ERR_BIT] = next_s.err_cnt != 3'h0;
    next_s.stb[smp_pkg::STB_MAV_BIT] = next_s.mav;
  end

  always_ff @(posedge mclk)
    if (rst)
      s <= '{st: S_START, level: smp_pkg::ROOT_NODE, default: '0};
    else
      s <= next_s;

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign tok_valid    = s.tok_valid;
  assign tok_is_param = s.tok_is_param;
  assign tok_node     = s.tok_node;
  assign tok_query    = s.tok_query;
  assign tok_data     = s.tok_data;
  assign err_pulse    = s.err_pulse;
  assign err_code     = s.err_code;
  assign path_level   = s.level;
  assign status_byte  = s.stb;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_nl_term_root: assert property (@(posedge mclk) disable iff (rst)
    pop && ch == smp_pkg::CH_NL |=> s.st == S_START && s.level == smp_pkg::ROOT_NODE)
    else $error("newline did not end message");
  a_strobe_term: assert property (@(posedge mclk) disable iff (rst)
    pop && f_data[8] |=> s.st == S_START && s.level == smp_pkg::ROOT_NODE)
    else $error("line end strobe did not end message");
  a_root_spec: assert property (@(posedge mclk) disable iff (rst)
    pop && !term && s.st == S_START && ch == smp_pkg::CH_COLON
    |=> s.level == smp_pkg::ROOT_NODE && s.st == S_KWSTART)
    else $error("root specifier did not reset path");
  a_sep_deeper: assert property (@(posedge mclk) disable iff (rst)
    pop && !term && s.st == S_KW && hit && ch == smp_pkg::CH_COLON
    |=> s.level == $past(hit_idx))
    else $error("separator did not move path down");
  a_query_mark: assert property (@(posedge mclk) disable iff (rst)
    pop && !term && s.st == S_KW && hit && ch == smp_pkg::CH_QUERY
    |=> s.tok_valid && s.tok_query && s.st == S_AFTQ)
    else $error("query mark not flagged");
  a_sibling_level: assert property (@(posedge mclk) disable iff (rst)
    pop && !term && s.st == S_KW && hit && ch == smp_pkg::CH_SEMI
    |=> s.level == $past(s.level) && s.st == S_START)
    else $error("unit separator changed path");
  a_bad_kw_err: assert property (@(posedge mclk) disable iff (rst)
    pop && !term && s.st == S_KW && !letter && !hit
    |=> s.err_pulse && s.st == S_DISCARD && status_byte[smp_pkg::STB_ERR_BIT])
    else $error("unknown keyword not reported");
  // A willing consumer keeps the input open only if every character costs one cycle
  a_drain_live: assert property (@(posedge mclk) disable iff (rst)
    tok_ready |=> char_ready)
    else $error("parser stalled on a character");
  a_mav_set: assert property (@(posedge mclk) disable iff (rst)
    s.tok_valid && tok_ready && !s.tok_is_param && s.tok_query
    |=> status_byte[smp_pkg::STB_MAV_BIT])
    else $error("response flag not set after query");
endmodule

// file: test/smp_host.sv
// Host controller model that sends program messages one character at a time
`timescale 1ns/1ns

module smp_host (
  input  wire logic       mclk,
  input  wire logic       char_ready,
  output logic            char_valid,
  output logic      [7:0] char_data,
  output logic            line_end_strobe
);
  initial
  begin
    char_valid      = 1'b0;
    char_data       = 8'h00;
    line_end_strobe = 1'b0;
  end

  // Held until an edge samples char_ready high; a released data bus shows the
  // inverse of the last character so a stale value never passes for a new one
  task automatic put(input logic [7:0] ch, input logic strobe, input int gap);
    @(negedge mclk);
    char_valid      = 1'b1;
    char_data       = ch;
    line_end_strobe = strobe;
    @(posedge mclk);
    while (char_ready !== 1'b1)
      @(posedge mclk);
    if (gap > 0)
    begin
      @(negedge mclk);
      char_valid      = 1'b0;
      char_data       = ~ch;
      line_end_strobe = 1'b0;
      repeat (gap - 1) @(negedge mclk);
    end
  endtask

  // Term: 0 none, 1 newline, 2 strobe with a random printable character
  task automatic send(input string msg, input int term, input logic gaps);
    for (int i = 0; i < msg.len(); i++)
      put(msg[i], 1'b0, (i == msg.len() - 1) ? 1 : (gaps ? $urandom_range(0, 2) : 0));
    if (term == 1)
      put(8'h0A, 1'b0, 1);
    if (term == 2)
      put(8'($urandom_range(33, 126)), 1'b1, 1);
  endtask
endmodule

// file: test/scpi_message_parser_test.sv
// Self-checking bench for the program message parser
`timescale 1ns/1ns

module scpi_message_parser_test;
  logic        mclk, rst, char_valid, line_end_strobe, char_ready, tok_valid, tok_ready;
  logic        tok_is_param, tok_query, err_pulse, err_ack, resp_taken, resp, saw_full;
  logic  [7:0] char_data, tok_data, status_byte;
  logic  [4:0] tok_node, path_level;
  logic  [1:0] err_code;
  int          num_errors, compares, cycles, stall, ecount;
  logic [14:0] got[$], exp[$];
  logic  [7:0] got_err[$], exp_err[$];
  string       roots[15] = '{"", "ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST",
    "MEASURE", "OUTPUT", "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE", "CURRENT",
    "FUNCTION"};

  smp_parser i_dut (.mclk(mclk), .rst(rst), .char_valid(char_valid), .char_data(char_data),
    .line_end_strobe(line_end_strobe), .char_ready(char_ready), .tok_valid(tok_valid),
    .tok_ready(tok_ready), .tok_is_param(tok_is_param), .tok_node(tok_node),
    .tok_query(tok_query), .tok_data(tok_data), .err_pulse(err_pulse), .err_code(err_code),
    .err_ack(err_ack), .resp_taken(resp_taken), .status_byte(status_byte),
    .path_level(path_level));
  smp_host i_host (.mclk(mclk), .char_ready(char_ready), .char_valid(char_valid),
    .char_data(char_data), .line_end_strobe(line_end_strobe));

  // --------------------------------
  // Clock, consumer and monitors
  // --------------------------------
  always #25 mclk = ~mclk;

  always @(negedge mclk)
    tok_ready <= (stall == 0) || (stall == 1 && $urandom_range(0, 2) != 0);

  always @(posedge mclk)
  begin
    cycles++;
    if (tok_valid === 1'b1 && tok_ready === 1'b1)
      got.push_back({tok_is_param, tok_node, tok_query, tok_data});
    if (err_pulse === 1'b1)
      got_err.push_back({6'h00, err_code});
    if (rst === 1'b0 && char_ready === 1'b0)
      saw_full = 1'b1;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  // --------------------------------
  // Expectations and comparisons
  // --------------------------------
  function automatic string short_of(input string s);
    if (s.len() <= 4)
      return s;
    if (s[3] inside {"A", "E", "I", "O", "U"})
      return s.substr(0, 2);
    return s.substr(0, 3);
  endfunction

  task automatic e_h(input logic [4:0] node, input logic q);
    exp.push_back({1'b0, node, q, 8'h00});
    resp = resp | q;
  endtask

  task automatic e_p(input logic [4:0] node, input string s);
    for (int i = 0; i < s.len(); i++)
      exp.push_back({1'b1, node, 1'b0, s[i]});
  endtask

  // Error count saturates at seven entries
  task automatic e_e(input logic [7:0] code);
    exp_err.push_back(code);
    if (ecount < 7)
      ecount++;
  endtask

  task automatic check_tok(input logic [14:0] act, input logic [14:0] want);
    compares++;
    if (act !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: token %h, expected %h", $time, act, want);
    end
  endtask

  task automatic check_val(input logic [7:0] act, input logic [7:0] want);
    compares++;
    if (act !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: value %h, expected %h", $time, act, want);
    end
  endtask

  // Sends one message, then compares tokens, errors, status and, when terminated, path
  task automatic run(input string msg, input int term, input int hold);
    int t;
    got.delete();
    got_err.delete();
    fork
      i_host.send(msg, term, hold == 0);
      if (hold > 0)
      begin
        repeat (hold) @(posedge mclk);
        stall = 0;
      end
    join
    t = 0;
    while ((got.size() < exp.size() || got_err.size() < exp_err.size()) && t < 300)
    begin
      @(posedge mclk);
      t++;
    end
    repeat (8) @(posedge mclk);
    check_val(8'(got.size() + 16 * got_err.size()), 8'(exp.size() + 16 * exp_err.size()));
    foreach (exp[i])
      if (i < got.size())
        check_tok(got[i], exp[i]);
    foreach (exp_err[i])
      if (i < got_err.size())
        check_val(got_err[i], exp_err[i]);
    if (term != 0)
      check_val({3'h0, path_level}, 8'h00);
    check_val(status_byte, {3'h0, resp, ecount != 0, 3'h0});
    if (resp)
    begin
      @(negedge mclk);
      resp_taken = 1'b1;
      @(negedge mclk);
      resp_taken = 1'b0;
      resp = 1'b0;
      @(posedge mclk);
      check_val(status_byte, {4'h0, ecount != 0, 3'h0});
    end
    exp.delete();
    exp_err.delete();
  endtask

  task automatic print_verdict();
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    string kw;
    string sf;
    int    k;
    logic  q;
    mclk = 1'b0;
    rst = 1'b1;
    err_ack = 1'b0;
    resp_taken = 1'b0;
    tok_ready = 1'b0;
    {stall, ecount, cycles, num_errors, compares} = '0;
    {resp, saw_full} = 2'h0;
    void'($urandom(89634));
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    e_h(12, 0);
    e_p(12, "5");
    run("VOLT 5", 1, 0);
    e_h(21, 1);
    e_h(22, 1);
    run("MEAS:VOLT?;CURR?", 1, 0);
    e_h(21, 1);
    e_h(13, 1);
    run("meas:volt?;:curr?", 1, 0);
    e_h(18, 1);
    e_h(19, 0);
    e_p(19, "16");
    saw_full = 1'b0;
    stall = 2;
    run("STAT:OPER:COND?;ENAB 16", 1, 60);
    check_val({7'h00, saw_full}, 8'h01);
    e_h(16, 0);
    run("STAT:PRESET", 1, 0);
    e_e(0);
    run("STAT:PRES", 1, 0);
    e_e(0);
    run("STAT:OPER:ENABL", 1, 0);
    e_h(23, 0);
    e_p(23, "7");
    run("SoUrCe:VoLtAgE:LeVeL 7", 1, 0);
    e_h(12, 0);
    e_p(12, "5");
    e_h(13, 0);
    e_p(13, "1");
    run("VOLT 5;CURR 1", 1, 0);
    e_e(0);
    run("FOO;VOLT 1", 1, 0);
    e_e(0);
    run("LEV", 1, 0);
    e_h(12, 0);
    e_e(2);
    run("VOLT  5", 1, 0);
    e_e(1);
    run("VOLT::LEV", 1, 0);
    run("TRIG", 0, 0);
    e_h(11, 0);
    run("", 1, 0);
    e_h(11, 0);
    run("trig", 2, 0);
    stall = 1;
    repeat (24)
    begin
      k = $urandom_range(1, 14);
      q = $urandom_range(0, 1);
      sf = short_of(roots[k]);
      if ($urandom_range(0, 3) == 0 && sf.len() + 1 < roots[k].len())
      begin
        kw = roots[k].substr(0, sf.len());
        e_e(0);
      end
      else
      begin
        kw = $urandom_range(0, 1) ? roots[k] : sf;
        e_h(5'(k), q);
      end
      for (int i = 0; i < kw.len(); i++)
        if ($urandom_range(0, 1) == 1)
          kw[i] = kw[i] ^ 8'h20;
      run(q ? {kw, "?"} : kw, 1, 0);
    end
    stall = 0;
    while (ecount > 0)
    begin
      @(negedge mclk);
      err_ack = 1'b1;
      @(negedge mclk);
      err_ack = 1'b0;
      ecount--;
    end
    repeat (2) @(posedge mclk);
    check_val(status_byte, 8'h00);
    print_verdict();
  end
endmodule
